// ==== verilog/wakeup_timer.sv ====
// Purpose: periodic wakeup timer with 24-bit up/down counter
// Assumes: register port on the core clock, pins need synchronising
// Notes: interrupt pins are open drain, enable low while driving
//
// Overview of operation
// - one resettable 24-bit up/down counter
// - source: four internal rates or event pin
// - auto release after 488 us or 7.812 ms, internal sources only
// - event source keeps pull, ignores filter, edge
// - direction bit: 1 up, 0 down
// - flag when passing preset or reaching zero
// - zero preset: no counting, no interrupt
// - period equals preset source periods
// - optional limit to normal or safe mode
// - counter holds outside permitted mode
// - interrupt routed to irq or freq pin
// - write zero clears flag, clear before enabling
// - writing enable one starts the counter
// - up count starts and reloads at one
// - down count starts and reloads at preset
// - suspend freezes unless mode limit is on, release resumes from value
`timescale 1ns/1ps
`include "wakeup_timer_defines.svh"

module wakeup_timer #(
  parameter logic [17:0] RELEASE_FAST_CYCLES = 18'(`RELEASE_FAST_CYCLES),
  parameter logic [17:0] RELEASE_SLOW_CYCLES = 18'(`RELEASE_SLOW_CYCLES)
) (
  input wire logic core_clk_in, // core clock, 20 MHz
  input wire logic rst_b_in, // async reset, active low
  input wire logic [7:0] addr_in, // register byte address
  input wire logic [31:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [31:0] rdata_out, // read data, cycle after strobe
  input wire logic rate_1024hz_in, // 1024 Hz square wave pin
  input wire logic event_in, // external event pin
  input wire logic safe_mode_in, // high while in safe mode
  output logic irq_pin_out, // interrupt pin level
  output logic irq_oe_n_out, // interrupt pin enable, low drives
  output logic freq_pin_out, // frequency pin level
  output logic freq_oe_n_out, // frequency pin enable, low drives
  output logic [1:0] event_pull_out // event pin pull setting
);

  wakeup_timer_pkg::ctrl_type ctrl;
  wakeup_timer_pkg::ctrl_type next_ctrl;
  wakeup_timer_pkg::mode_type mode;
  wakeup_timer_pkg::mode_type next_mode;
  wakeup_timer_pkg::run_state_type state;
  wakeup_timer_pkg::run_state_type next_state;
  logic [23:0] preset;
  logic [23:0] next_preset;
  logic [23:0] count;
  logic [23:0] next_count;
  logic flag;
  logic next_flag;
  logic released;
  logic next_released;
  logic [17:0] rel_cnt;
  logic [17:0] next_rel_cnt;
  logic [17:0] rel_limit;
  logic [31:0] next_rdata;
  logic source_tick;
  logic safe_mode;
  logic mode_ok;
  logic count_ok;
  logic wrap;
  logic wrap_event;
  logic flag_clear;
  logic assert_req;
  logic drive;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // source clock
  source_select source_select_inst (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .rate_1024hz_in(rate_1024hz_in),
    .event_in(event_in),
    .safe_mode_in(safe_mode_in),
    .external_source_select_in(ctrl.external_source_select),
    .source_rate_select_in(ctrl.source_rate_select),
    .source_tick_out(source_tick),
    .safe_mode_out(safe_mode)
  );

  //////////////////////////////////////////////////////////////////////
  // registers
  always_comb begin
    next_ctrl = ctrl;
    next_mode = mode;
    next_preset = preset;
    flag_clear = 1'b0;
    if (wr_in) begin
      if (hit(addr_in, `ADDR_CTRL)) begin
        next_ctrl = wakeup_timer_pkg::ctrl_type'(wdata_in[7:0]);
      end
      if (hit(addr_in, `ADDR_MODE)) begin
        next_mode = wakeup_timer_pkg::mode_type'(wdata_in[4:0]);
      end
      if (hit(addr_in, `ADDR_PRESET_LOW)) begin
        next_preset[7:0] = wdata_in[7:0];
      end
      if (hit(addr_in, `ADDR_PRESET_MID)) begin
        next_preset[15:8] = wdata_in[7:0];
      end
      if (hit(addr_in, `ADDR_PRESET_HIGH)) begin
        next_preset[23:16] = wdata_in[7:0];
      end
      if (hit(addr_in, `ADDR_STATUS)) begin
        flag_clear = ~wdata_in[`STATUS_FLAG_BIT];
      end
    end
    next_rdata = 32'h00000000;
    if (rd_in) begin
      case (addr_in)
        `ADDR_CTRL: next_rdata = {24'h000000, ctrl};
        `ADDR_MODE: next_rdata = {27'h0000000, mode};
        `ADDR_PRESET_LOW: next_rdata = {24'h000000, preset[7:0]};
        `ADDR_PRESET_MID: next_rdata = {24'h000000, preset[15:8]};
        `ADDR_PRESET_HIGH: next_rdata = {24'h000000, preset[23:16]};
        `ADDR_STATUS: next_rdata = {29'h00000000, drive,
                                    (state == wakeup_timer_pkg::st_count),
                                    flag};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= wakeup_timer_pkg::ctrl_type'(`CTRL_RESET);
      mode <= wakeup_timer_pkg::mode_type'(`MODE_RESET);
      preset <= `PRESET_RESET;
      rdata_out <= 32'h00000000;
      event_pull_out <= 2'h0;
    end else begin
      ctrl <= next_ctrl;
      mode <= next_mode;
      preset <= next_preset;
      rdata_out <= next_rdata;
      event_pull_out <= next_mode.event_pull;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // counter
  always_comb begin
    mode_ok = ~mode.mode_condition_enable |
              (mode.mode_condition_select == safe_mode);
    // suspend only counts while the mode condition is off
    count_ok = ctrl.timer_enable & (preset != `PRESET_NONE) & mode_ok &
               (mode.mode_condition_enable |
                ~mode.suspend_request);
    wrap = ctrl.count_direction_select ? (count == preset) :
           (count == `DOWN_LAST);
    wrap_event = 1'b0;
    next_state = state;
    next_count = count;
    case (state)
      wakeup_timer_pkg::st_idle: begin
        if (ctrl.timer_enable) begin
          next_state = wakeup_timer_pkg::st_count;
          next_count = ctrl.count_direction_select ? `UP_START :
                       preset;
        end
      end
      wakeup_timer_pkg::st_count: begin
        if (!ctrl.timer_enable) begin
          next_state = wakeup_timer_pkg::st_idle;
        end else if (count_ok && source_tick) begin
          if (wrap) begin
            wrap_event = 1'b1;
            next_count = ctrl.count_direction_select ? `UP_START :
                         preset;
          end else if (ctrl.count_direction_select) begin
            next_count = count + 24'h000001;
          end else begin
            next_count = count - 24'h000001;
          end
        end
      end
      default: next_state = wakeup_timer_pkg::st_idle;
    endcase
    // a new event beats a clear in the same cycle
    next_flag = wrap_event | (flag & ~flag_clear);
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= wakeup_timer_pkg::st_idle;
      count <= 24'h000000;
      flag <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      flag <= next_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt pin and auto release
  always_comb begin
    assert_req = flag & ctrl.period_irq_allow;
    drive = assert_req & ~released;
    rel_limit = (ctrl.source_rate_select == `RATE_1024HZ) ?
                RELEASE_FAST_CYCLES : RELEASE_SLOW_CYCLES;
    next_rel_cnt = drive ? rel_cnt + 18'h00001 : 18'h00000;
    next_released = assert_req & (released |
                    (drive & ctrl.auto_release_enable &
                     ~ctrl.external_source_select &
                     (rel_cnt == rel_limit - 18'h00001)));
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rel_cnt <= 18'h00000;
      released <= 1'b0;
      irq_pin_out <= 1'b1;
      irq_oe_n_out <= 1'b1;
      freq_pin_out <= 1'b1;
      freq_oe_n_out <= 1'b1;
    end else begin
      rel_cnt <= next_rel_cnt;
      released <= next_released;
      irq_pin_out <= ~(drive & ~ctrl.irq_pin_select);
      irq_oe_n_out <= ~(drive & ~ctrl.irq_pin_select);
      freq_pin_out <= ~(drive & ctrl.irq_pin_select);
      freq_oe_n_out <= ~(drive & ctrl.irq_pin_select);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_up_wrap_reload: assert property (
    (state == wakeup_timer_pkg::st_count && ctrl.timer_enable && count_ok
     && source_tick && ctrl.count_direction_select && count == preset)
    |=> (count == `UP_START) && flag)
    else $error("up wrap did not reload one and set flag");

  a_down_wrap_reload: assert property (
    (state == wakeup_timer_pkg::st_count && ctrl.timer_enable && count_ok
     && source_tick && !ctrl.count_direction_select && count == 24'h1)
    |=> (count == $past(preset)) && flag)
    else $error("down wrap did not reload preset and set flag");

  a_zero_no_event: assert property (
    (preset == `PRESET_NONE && !flag) |=> !flag)
    else $error("flag set with zero preset");

  a_hold_blocked: assert property (
    (state == wakeup_timer_pkg::st_count && !count_ok) |=> $stable(count))
    else $error("counter moved while counting blocked");

  a_step_one: assert property (
    (state == wakeup_timer_pkg::st_count && ctrl.timer_enable && count_ok
     && source_tick && !wrap)
    |=> count == ($past(ctrl.count_direction_select) ?
                  $past(count) + 24'h1 : $past(count) - 24'h1))
    else $error("counter step not exactly one");

  a_no_tick_stable: assert property (
    (state == wakeup_timer_pkg::st_count && !source_tick) |=> $stable(count))
    else $error("counter moved without a source edge");

  a_flag_clear: assert property (
    (flag && wr_in && addr_in == `ADDR_STATUS && !wdata_in[0] && !wrap_event)
    |=> !flag)
    else $error("flag not cleared by writing zero");

  a_start_load: assert property (
    (state == wakeup_timer_pkg::st_idle && ctrl.timer_enable)
    |=> state == wakeup_timer_pkg::st_count &&
        count == ($past(ctrl.count_direction_select) ? `UP_START :
                  $past(preset)))
    else $error("start did not load the initial value");

  a_release_done: assert property (
    (drive && ctrl.auto_release_enable && !ctrl.external_source_select &&
     rel_cnt == rel_limit - 18'h1 && !$changed(ctrl))
    |=> !drive ##1 irq_oe_n_out && freq_oe_n_out)
    else $error("interrupt not released after its time");

  a_ext_no_release: assert property (
    (drive && ctrl.external_source_select) |=> released == $past(released))
    else $error("external source released the interrupt");

  a_pin_exclusive: assert property (
    !(!irq_oe_n_out && !freq_oe_n_out))
    else $error("both interrupt pins driven");

  c_up_wrap: cover property (
    wrap_event && ctrl.count_direction_select);
  c_down_wrap: cover property (
    wrap_event && !ctrl.count_direction_select);
  c_auto_release: cover property ($rose(released));
  c_suspend_hold: cover property (
    state == wakeup_timer_pkg::st_count && mode.suspend_request &&
    source_tick);

endmodule // wakeup_timer

// ==== verilog/wakeup_timer_defines.svh ====
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 20 MHz core clock, byte addresses on the register port
// Notes: included by bare name from every file but the package
`ifndef WAKEUP_TIMER_DEFINES_SVH
`define WAKEUP_TIMER_DEFINES_SVH

`define ADDR_CTRL 8'h00
`define ADDR_MODE 8'h04
`define ADDR_PRESET_LOW 8'h08
`define ADDR_PRESET_MID 8'h0c
`define ADDR_PRESET_HIGH 8'h10
`define ADDR_STATUS 8'h14

`define CTRL_RESET 8'h00
`define MODE_RESET 5'h00
`define PRESET_RESET 24'h000000
`define STATUS_FLAG_BIT 0

`define RATE_1024HZ 2'b00
`define RATE_64HZ 2'b01
`define RATE_1HZ 2'b10
`define RATE_1_60HZ 2'b11

`define UP_START 24'h000001
`define DOWN_LAST 24'h000001
`define PRESET_NONE 24'h000000

`define DIV_64_LAST 4'hf
`define DIV_1_LAST 10'h3ff
`define MINUTE_LAST 6'h3b

`define CLK_PERIOD_NS 50
`define RELEASE_FAST_NS 488000
`define RELEASE_SLOW_NS 7812000
`define RELEASE_FAST_CYCLES (`RELEASE_FAST_NS / `CLK_PERIOD_NS)
`define RELEASE_SLOW_CYCLES (`RELEASE_SLOW_NS / `CLK_PERIOD_NS)

`endif

// ==== verilog/wakeup_timer_pkg.sv ====
// Purpose: types shared by the wakeup timer files
// Assumes: nothing
// Notes: fields listed msb first
package wakeup_timer_pkg;

  typedef struct packed {
    logic period_irq_allow;
    logic irq_pin_select;
    logic auto_release_enable;
    logic count_direction_select;
    logic external_source_select;
    logic [1:0] source_rate_select;
    logic timer_enable;
  } ctrl_type;

  typedef struct packed {
    logic [1:0] event_pull;
    logic suspend_request;
    logic mode_condition_select;
    logic mode_condition_enable;
  } mode_type;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_count = 2'b01
  } run_state_type;

endpackage

// ==== verilog/source_select.sv ====
// Purpose: synchronise pins, prescale 1024 Hz, pick the source tick
// Assumes: rate and event pins are slow against the core clock
// Notes: tick output is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
`include "wakeup_timer_defines.svh"

module source_select (
  input wire logic core_clk_in, // core clock
  input wire logic rst_b_in, // async reset, active low
  input wire logic rate_1024hz_in, // 1024 Hz square wave pin
  input wire logic event_in, // external event pin
  input wire logic safe_mode_in, // high while in safe mode
  input wire logic external_source_select_in, // 1: event pin
  input wire logic [1:0] source_rate_select_in, // internal rate
  output logic source_tick_out, // one pulse per source edge
  output logic safe_mode_out // synchronised safe mode level
);

  function automatic logic rise_of(input logic prev, input logic cur);
    rise_of = cur & ~prev;
  endfunction

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] next_sync_a;
  logic [2:0] next_sync_b;
  logic rate_prev;
  logic event_prev;
  logic [9:0] div_cnt;
  logic [9:0] next_div_cnt;
  logic [5:0] minute_cnt;
  logic [5:0] next_minute_cnt;
  logic next_tick;
  logic tick1024;
  logic tick64;
  logic tick1;
  logic tick60;
  logic tick_ext;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_sync_a = {safe_mode_in, event_in, rate_1024hz_in};
    next_sync_b = sync_a;
    tick1024 = rise_of(rate_prev, sync_b[0]);
    // raw synchronised edge, no filter and no edge option here
    tick_ext = rise_of(event_prev, sync_b[1]);
    tick64 = tick1024 & (div_cnt[3:0] == `DIV_64_LAST);
    tick1 = tick1024 & (div_cnt == `DIV_1_LAST);
    tick60 = tick1 & (minute_cnt == `MINUTE_LAST);
    next_div_cnt = tick1024 ? div_cnt + 10'h001 : div_cnt;
    next_minute_cnt = minute_cnt;
    if (tick1) begin
      next_minute_cnt = tick60 ? 6'h00 : minute_cnt + 6'h01;
    end
    if (external_source_select_in) begin
      next_tick = tick_ext;
    end else begin
      case (source_rate_select_in)
        `RATE_1024HZ: next_tick = tick1024;
        `RATE_64HZ: next_tick = tick64;
        `RATE_1HZ: next_tick = tick1;
        `RATE_1_60HZ: next_tick = tick60;
        default: next_tick = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      rate_prev <= 1'b0;
      event_prev <= 1'b0;
      div_cnt <= 10'h000;
      minute_cnt <= 6'h00;
      source_tick_out <= 1'b0;
      safe_mode_out <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      rate_prev <= sync_b[0];
      event_prev <= sync_b[1];
      div_cnt <= next_div_cnt;
      minute_cnt <= next_minute_cnt;
      source_tick_out <= next_tick;
      safe_mode_out <= sync_b[2];
    end
  end

endmodule // source_select

// ==== sim/wakeup_timer_tb_top.sv ====
// Purpose: self-checking bench for the wakeup timer
// Assumes: short release counts, rate pin driven by the bench
// Notes: each scenario is a task that judges its own outcome
`timescale 1ns/1ps
`include "wakeup_timer_defines.svh"

`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  n_mismatch++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module wakeup_timer_tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic rate = 1'b0;
  logic ev = 1'b0;
  logic safe = 1'b0;
  logic [31:0] rdata;
  logic irq_pin, irq_oe_n, freq_pin, freq_oe_n;
  logic [1:0] pull;
  logic [31:0] rv;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int run = 0;
  int last_run = 0;

  wakeup_timer #(.RELEASE_FAST_CYCLES(18'h8),
    .RELEASE_SLOW_CYCLES(18'h14)) wakeup_timer_inst (
    .core_clk_in(core_clk), .rst_b_in(rst_b), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .rate_1024hz_in(rate), .event_in(ev), .safe_mode_in(safe),
    .irq_pin_out(irq_pin), .irq_oe_n_out(irq_oe_n),
    .freq_pin_out(freq_pin), .freq_oe_n_out(freq_oe_n),
    .event_pull_out(pull));

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////
  // length of the last low stretch of the interrupt pin
  always @(posedge core_clk) begin
    cyc++;
    if (irq_oe_n === 1'b0) run++;
    else begin
      if (run != 0) last_run = run;
      run = 0;
    end
    if (cyc == 40000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge core_clk);
    wr_s <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge core_clk);
    rd_s <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic edges(input int n, input int h = 6);
    repeat (n) begin
      @(posedge core_clk) rate <= 1'b1;
      repeat (h) @(posedge core_clk);
      rate <= 1'b0;
      repeat (h) @(posedge core_clk);
    end
  endtask

  // event highs stay long against the sample rate
  task automatic evs(input int n);
    repeat (n) begin
      @(posedge core_clk) ev <= 1'b1;
      repeat (6) @(posedge core_clk);
      ev <= 1'b0;
      repeat (6) @(posedge core_clk);
    end
  endtask

  task automatic flag_is(input logic exp);
    rd(`ADDR_STATUS);
    `CHK(rv[0], exp)
  endtask

  task automatic setup(input logic [7:0] c, input logic [23:0] p,
                       input logic [7:0] m);
    wr(`ADDR_CTRL, 32'h0);
    wr(`ADDR_CTRL, {24'h0, 4'h0, c[3:1], 1'b0});
    wr(`ADDR_PRESET_LOW, {24'h0, p[7:0]});
    wr(`ADDR_PRESET_MID, {24'h0, p[15:8]});
    wr(`ADDR_PRESET_HIGH, {24'h0, p[23:16]});
    wr(`ADDR_CTRL, {24'h0, 1'b0, c[6:1], 1'b0});
    wr(`ADDR_MODE, {24'h0, m});
    wr(`ADDR_STATUS, 32'h0);
    wr(`ADDR_CTRL, {24'h0, c[7:1], 1'b1});
    last_run = 0;
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] a[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    wr(8'h20, 32'hff);
    foreach (a[i]) begin
      rd(a[i]);
      `CHK(rv, 32'h0)
    end
    wr(`ADDR_PRESET_MID, 32'h5a);
    rd(`ADDR_PRESET_MID);
    `CHK(rv, 32'h5a)
    @(posedge core_clk) #1;
    `CHK(rdata, 32'h0)
    `CHK({irq_oe_n, freq_oe_n}, 2'b11)
    $display("test reset done");
  endtask

  task automatic t_up();
    setup(8'h90, 24'h000003, 8'h00);
    edges(2);
    flag_is(1'b0);
    edges(1);
    flag_is(1'b1);
    `CHK(rv[2:0], 3'h7)
    `CHK({irq_pin, irq_oe_n, freq_oe_n}, 3'b001)
    wr(`ADDR_STATUS, 32'h1);
    flag_is(1'b1);
    wr(`ADDR_STATUS, 32'h0);
    repeat (2) @(posedge core_clk);
    `CHK(irq_oe_n, 1'b1)
    edges(2);
    flag_is(1'b0);
    edges(1);
    flag_is(1'b1);
    $display("test up done");
  endtask

  task automatic t_down();
    setup(8'h80, 24'h000002, 8'h00);
    edges(1);
    flag_is(1'b0);
    edges(1);
    flag_is(1'b1);
    wr(`ADDR_STATUS, 32'h0);
    edges(1);
    flag_is(1'b0);
    edges(1);
    flag_is(1'b1);
    wr(`ADDR_CTRL, 32'h80);
    wr(`ADDR_STATUS, 32'h0);
    edges(3);
    flag_is(1'b0);
    $display("test down done");
  endtask

  task automatic t_zero();
    setup(8'h90, 24'h000000, 8'h00);
    edges(4);
    flag_is(1'b0);
    `CHK(irq_oe_n, 1'b1)
    $display("test zero done");
  endtask

  task automatic t_release();
    setup(8'ha0, 24'h000001, 8'h00);
    edges(1);
    repeat (30) @(posedge core_clk);
    `CHK(last_run, 8)
    `CHK(irq_oe_n, 1'b1)
    flag_is(1'b1);
    `CHK(rv[2:1], 2'b01)
    setup(8'ha2, 24'h000002, 8'h00);
    edges(16);
    flag_is(1'b0);
    edges(16);
    flag_is(1'b1);
    repeat (30) @(posedge core_clk);
    `CHK(last_run, 20)
    $display("test release done");
  endtask

  task automatic t_pinsel();
    setup(8'hc0, 24'h000001, 8'h00);
    edges(1);
    `CHK({freq_pin, freq_oe_n, irq_oe_n}, 3'b001)
    $display("test pin select done");
  endtask

  task automatic t_ext();
    setup(8'ha8, 24'h000002, 8'h10);
    `CHK(pull, 2'b10)
    edges(4);
    flag_is(1'b0);
    evs(1);
    flag_is(1'b0);
    evs(1);
    flag_is(1'b1);
    repeat (30) @(posedge core_clk);
    `CHK(irq_oe_n, 1'b0)
    $display("test external done");
  endtask

  task automatic t_mode();
    setup(8'h80, 24'h000003, 8'h01);
    edges(1);
    safe <= 1'b1;
    repeat (4) @(posedge core_clk);
    edges(3);
    flag_is(1'b0);
    safe <= 1'b0;
    repeat (4) @(posedge core_clk);
    edges(1);
    flag_is(1'b0);
    edges(1);
    flag_is(1'b1);
    wr(`ADDR_STATUS, 32'h0);
    wr(`ADDR_MODE, 32'h04);
    edges(5);
    flag_is(1'b0);
    wr(`ADDR_MODE, 32'h00);
    edges(2);
    flag_is(1'b0);
    edges(1);
    flag_is(1'b1);
    wr(`ADDR_STATUS, 32'h0);
    wr(`ADDR_MODE, 32'h03);
    edges(3);
    flag_is(1'b0);
    safe <= 1'b1;
    repeat (4) @(posedge core_clk);
    edges(3);
    flag_is(1'b1);
    safe <= 1'b0;
    $display("test mode done");
  endtask

  // one 1 Hz step per 1024 rate edges, whatever the prescaler phase
  task automatic t_slow();
    setup(8'h84, 24'h000002, 8'h00);
    edges(1024, 2);
    flag_is(1'b0);
    edges(1024, 2);
    flag_is(1'b1);
    $display("test slow rate done");
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_up();
    t_down();
    t_zero();
    t_release();
    t_pinsel();
    t_ext();
    t_mode();
    t_slow();
    final_report();
  end
endmodule // wakeup_timer_tb_top
